// >>> inc/tarf_pkg.sv
// tarf_pkg: shared constants and types for the trigger-arm and reading formatter.
// assumes a single 100 MHz core clock domain.
package tarf_pkg;
  localparam int TARF_CLK_MHZ = 100;
  localparam int TARF_RD_W = 64;
  localparam int TARF_CNT_W = 16;
  localparam logic [15:0] TARF_TRIG_COUNT_RST = 16'h0001;
  localparam logic [7:0] TARF_CH_HASH = 8'h23;
  localparam logic [7:0] TARF_CH_ZERO = 8'h30;
  localparam logic [7:0] TARF_CH_PLUS = 8'h2B;
  localparam logic [7:0] TARF_CH_MINUS = 8'h2D;
  localparam logic [7:0] TARF_CH_DOT = 8'h2E;
  localparam logic [7:0] TARF_CH_EXP = 8'h45;
  localparam logic [7:0] TARF_CH_COMMA = 8'h2C;
  localparam logic [7:0] TARF_CH_LF = 8'h0A;
  localparam logic [4:0] TARF_ASCII_LEN = 5'h0F;
  localparam logic [3:0] TARF_R32_BYTES = 4'h4;
  localparam logic [3:0] TARF_R64_BYTES = 4'h8;
  localparam int TARF_LEN_DIGITS = 5;

  typedef enum logic [1:0] {
    TARF_CMD_NONE = 2'h0,
    TARF_CMD_MEAS = 2'h1,
    TARF_CMD_READ = 2'h2,
    TARF_CMD_INIT = 2'h3
  } tarf_cmd_t;

  typedef enum logic [1:0] {
    TARF_FMT_ASCII = 2'h0,
    TARF_FMT_REAL32 = 2'h1,
    TARF_FMT_REAL64 = 2'h2
  } tarf_fmt_t;

  typedef enum logic [3:0] {
    TARF_ST_IDLE = 4'b0001,
    TARF_ST_WAIT = 4'b0010,
    TARF_ST_MEAS = 4'b0100,
    TARF_ST_EMIT = 4'b1000
  } tarf_state_t;
endpackage

// >>> verilog/tarf_dec_digit.sv
// tarf_dec_digit: one decimal digit of a value, as an ascii character.
// purely combinational; the caller registers the result.
`timescale 1ns/1ps
module tarf_dec_digit import tarf_pkg::*; #(
  parameter int POS = 0
) (
  input wire logic [23:0] value,
  output logic [7:0] ch
);
  // 24 bits: seven decimal digits need more than 20
  logic [23:0] q;
  always_comb begin
    q = value;
    for (int i = 0; i < POS; i++) begin
      q = q / 24'd10;
    end
    ch = TARF_CH_ZERO + 8'(q % 24'd10);
  end
endmodule

// >>> verilog/tarf_core.sv
// tarf_core: arms on measure/read/init commands, waits for trigger, and
// streams readings to the host as ascii or a definite-length real block, or to memory on init.
// assumes the measurement engine answers meas_start with one rd_valid.
`timescale 1ns/1ps
// Behaviour
// R1 - A measurement starts only when a trigger is seen in the wait-for-trigger state.
// R2 - The measure command applies its configuration and arms itself.
// R3 - After configure-only the host must arm; read arms and returns readings to the host.
// R4 - Init arms and sends readings to memory instead of the host.
// R5 - With the immediate trigger source, arming starts measuring at once.
// R6 - With another source, arming only waits until that source triggers.
// R7 - Format selects ascii, real 32 or real 64 for all later readings.
// R8 - Real readings go out as a hash, a digit count, then the byte count digits.
// R9 - The block byte count is four or eight times the number of readings.
// R10 - Triggered scans repeat the configured count, default one, then return to idle.
// R11 - An ascii reading is sign, mantissa with six decimals, signed three-digit exponent.
module tarf_core import tarf_pkg::*; #(
  parameter int RD_W = TARF_RD_W,
  parameter int CNT_W = TARF_CNT_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire tarf_cmd_t cmd,
  input wire logic fmt_wr,
  input wire tarf_fmt_t fmt_in,
  input wire logic [CNT_W-1:0] trig_count_in,
  input wire logic trig_count_wr,
  input wire logic trig_imm,
  input wire logic trig_in,
  output logic meas_start,
  input wire logic rd_valid,
  input wire logic [RD_W-1:0] rd_data,
  input wire logic rd_neg,
  input wire logic [23:0] rd_mant,
  input wire logic rd_exp_neg,
  input wire logic [9:0] rd_exp,
  output logic out_valid,
  output logic [7:0] out_byte,
  output logic out_last,
  input wire logic out_ready,
  output logic mem_valid,
  output logic [RD_W-1:0] mem_data,
  output logic busy
);
  tarf_state_t st_r, st_nxt;
  tarf_fmt_t fmt_r, fmt_nxt;
  logic [CNT_W-1:0] tcnt_r, tcnt_nxt, left_r, left_nxt;
  logic to_mem_r, to_mem_nxt, meas_r, meas_nxt, mv_r, mv_nxt;
  logic [RD_W-1:0] md_r, md_nxt, hold_r, hold_nxt;
  logic [7:0] ob_r, ob_nxt;
  logic ov_r, ov_nxt, ol_r, ol_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic [7:0] hdr_r [0:6];
  logic [7:0] asc_r [0:14];
  logic [7:0] hdr_nxt [0:6];
  logic [7:0] asc_nxt [0:14];
  logic [4:0] hlen_r, hlen_nxt;
  logic [7:0] mdig [0:6];
  logic [7:0] edig [0:2];
  logic [7:0] ldig [0:TARF_LEN_DIGITS-1];
  logic [23:0] blen;
  logic [3:0] bpr;
  logic arm, trig_ok, last_scan;

  // one digit decoder per character position, sharing one module
  genvar g;
  for (g = 0; g < 7; g++) begin : g_mant
    tarf_dec_digit #(.POS(g)) u_m (.value(rd_mant), .ch(mdig[g]));
  end
  for (g = 0; g < 3; g++) begin : g_exp
    tarf_dec_digit #(.POS(g)) u_e (.value({14'h0000, rd_exp}), .ch(edig[g]));
  end
  for (g = 0; g < TARF_LEN_DIGITS; g++) begin : g_len
    tarf_dec_digit #(.POS(g)) u_l (.value(blen), .ch(ldig[g]));
  end

  assign bpr = (fmt_r == TARF_FMT_REAL64) ? TARF_R64_BYTES : TARF_R32_BYTES;
  // one reading per block: byte count is bytes per reading [R9]
  assign blen = {20'h00000, bpr};
  assign arm = (cmd == TARF_CMD_MEAS) || (cmd == TARF_CMD_READ) || (cmd == TARF_CMD_INIT);
  assign trig_ok = trig_imm || trig_in; // [R5] [R6]
  assign last_scan = (left_r <= {{(CNT_W-1){1'b0}}, 1'b1});

  always_comb begin
    st_nxt = st_r;
    fmt_nxt = fmt_r;
    tcnt_nxt = tcnt_r;
    left_nxt = left_r;
    to_mem_nxt = to_mem_r;
    meas_nxt = 1'b0;
    mv_nxt = 1'b0;
    md_nxt = md_r;
    hold_nxt = hold_r;
    ob_nxt = ob_r;
    ov_nxt = ov_r;
    ol_nxt = ol_r;
    idx_nxt = idx_r;
    hlen_nxt = hlen_r;
    for (int i = 0; i < 7; i++) hdr_nxt[i] = hdr_r[i];
    for (int i = 0; i < 15; i++) asc_nxt[i] = asc_r[i];
    // format change only between acquisitions, applies to later readings
    if (fmt_wr && st_r == TARF_ST_IDLE) fmt_nxt = fmt_in; // [R7]
    if (trig_count_wr && st_r == TARF_ST_IDLE) tcnt_nxt = trig_count_in;
    case (st_r)
      TARF_ST_IDLE: begin
        // no arming command means no wait state: configure alone never measures [R3]
        if (arm) begin
          st_nxt = TARF_ST_WAIT; // [R2] [R3] [R4]
          to_mem_nxt = (cmd == TARF_CMD_INIT); // [R4]
          left_nxt = (tcnt_r == '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : tcnt_r;
        end
      end
      TARF_ST_WAIT: begin
        if (trig_ok) begin
          st_nxt = TARF_ST_MEAS; // [R1]
          meas_nxt = 1'b1;
        end
      end
      TARF_ST_MEAS: begin
        if (rd_valid) begin
          if (to_mem_r) begin
            mv_nxt = 1'b1;
            md_nxt = rd_data; // [R4]
            st_nxt = last_scan ? TARF_ST_IDLE : TARF_ST_WAIT; // [R10]
            left_nxt = left_r - 1'b1;
          end else begin
            hold_nxt = rd_data;
            idx_nxt = '0;
            // header: '#', digit count, then count digits [R8]
            hdr_nxt[0] = TARF_CH_HASH;
            hdr_nxt[1] = TARF_CH_ZERO + 8'd1;
            hdr_nxt[2] = ldig[0];
            hlen_nxt = 5'd3 + ((fmt_r == TARF_FMT_REAL64) ? 5'd8 : 5'd4);
            asc_nxt[0] = rd_neg ? TARF_CH_MINUS : TARF_CH_PLUS; // [R11]
            asc_nxt[1] = mdig[6];
            asc_nxt[2] = TARF_CH_DOT;
            for (int i = 0; i < 6; i++) asc_nxt[3+i] = mdig[5-i];
            asc_nxt[9] = TARF_CH_EXP;
            asc_nxt[10] = rd_exp_neg ? TARF_CH_MINUS : TARF_CH_PLUS;
            for (int i = 0; i < 3; i++) asc_nxt[11+i] = edig[2-i];
            asc_nxt[14] = last_scan ? TARF_CH_LF : TARF_CH_COMMA;
            st_nxt = TARF_ST_EMIT; // [R3]
          end
        end
      end
      TARF_ST_EMIT: begin
        if (!ov_r || out_ready) begin
          if ((fmt_r == TARF_FMT_ASCII && idx_r == TARF_ASCII_LEN) ||
              (fmt_r != TARF_FMT_ASCII && idx_r == hlen_r)) begin
            ov_nxt = 1'b0;
            ol_nxt = 1'b0;
            st_nxt = last_scan ? TARF_ST_IDLE : TARF_ST_WAIT; // [R10]
            left_nxt = left_r - 1'b1;
          end else begin
            ov_nxt = 1'b1;
            if (fmt_r == TARF_FMT_ASCII) begin
              ob_nxt = asc_r[idx_r[3:0]]; // [R11]
              ol_nxt = last_scan && (idx_r == TARF_ASCII_LEN - 5'd1);
            end else if (idx_r < 5'd3) begin
              ob_nxt = hdr_r[idx_r[2:0]]; // [R8]
              ol_nxt = 1'b0;
            end else begin
              // big-endian payload bytes, bpr of them [R9]
              ob_nxt = hold_r[8*(5'(bpr) - 5'(idx_r - 5'd3)) - 1 -: 8];
              ol_nxt = last_scan && (idx_r == hlen_r - 5'd1);
            end
            idx_nxt = idx_r + 5'd1;
          end
        end
      end
      default: st_nxt = TARF_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= TARF_ST_IDLE;
      fmt_r <= TARF_FMT_ASCII;
      tcnt_r <= TARF_TRIG_COUNT_RST;
      left_r <= '0;
      to_mem_r <= 1'b0;
      meas_r <= 1'b0;
      mv_r <= 1'b0;
      md_r <= '0;
      hold_r <= '0;
      ob_r <= 8'h00;
      ov_r <= 1'b0;
      ol_r <= 1'b0;
      idx_r <= 5'h00;
      hlen_r <= 5'h00;
      for (int i = 0; i < 7; i++) hdr_r[i] <= 8'h00;
      for (int i = 0; i < 15; i++) asc_r[i] <= 8'h00;
    end else begin
      st_r <= st_nxt;
      fmt_r <= fmt_nxt;
      tcnt_r <= tcnt_nxt;
      left_r <= left_nxt;
      to_mem_r <= to_mem_nxt;
      meas_r <= meas_nxt;
      mv_r <= mv_nxt;
      md_r <= md_nxt;
      hold_r <= hold_nxt;
      ob_r <= ob_nxt;
      ov_r <= ov_nxt;
      ol_r <= ol_nxt;
      idx_r <= idx_nxt;
      hlen_r <= hlen_nxt;
      for (int i = 0; i < 7; i++) hdr_r[i] <= hdr_nxt[i];
      for (int i = 0; i < 15; i++) asc_r[i] <= asc_nxt[i];
    end
  end

  logic busy_r;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) busy_r <= 1'b0;
    else busy_r <= (st_nxt != TARF_ST_IDLE);
  end

  assign meas_start = meas_r;
  assign mem_valid = mv_r;
  assign mem_data = md_r;
  assign out_valid = ov_r;
  assign out_byte = ob_r;
  assign out_last = ol_r;
  assign busy = busy_r;
endmodule

// >>> testbench/tarf_core_chk.sv
// tarf_core_chk: port timing checks for tarf_core.
// bound to every tarf_core; one core_clk domain.
`timescale 1ns/1ps
module tarf_core_chk import tarf_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire tarf_cmd_t cmd,
  input wire logic trig_imm,
  input wire logic meas_start,
  input wire logic rd_valid,
  input wire logic out_valid,
  input wire logic [7:0] out_byte,
  input wire logic out_ready,
  input wire logic out_last,
  input wire logic mem_valid,
  input wire logic busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  cmd_arms_a: assert property (!busy && cmd != TARF_CMD_NONE |=> busy)
    else $error("command in idle did not arm");
  imm_start_a: assert property (!busy && cmd != TARF_CMD_NONE && trig_imm |-> ##2 meas_start)
    else $error("immediate arm did not start");
  idle_quiet_a: assert property (!busy |=> !meas_start)
    else $error("start while idle");
  start_once_a: assert property (meas_start |=> !meas_start)
    else $error("start longer than one cycle");
  answer_due_a: assert property (rd_valid |-> ##[1:2] (mem_valid || out_valid))
    else $error("reading not passed on");
  mem_once_a: assert property (mem_valid |=> !mem_valid)
    else $error("memory write repeated");
  byte_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
    else $error("byte dropped under stall");
  last_gap_a: assert property (out_valid && out_ready && out_last |=> !out_valid)
    else $error("no gap after final byte");
  cover property (meas_start);
  cover property (mem_valid);
  cover property (out_valid && out_ready && out_last);
endmodule
bind tarf_core tarf_core_chk chk (.core_clk(core_clk), .reset(reset), .cmd(cmd),
  .trig_imm(trig_imm), .meas_start(meas_start), .rd_valid(rd_valid), .out_valid(out_valid),
  .out_byte(out_byte), .out_ready(out_ready), .out_last(out_last), .mem_valid(mem_valid),
  .busy(busy));

// >>> testbench/tarf_meas_model.sv
// tarf_meas_model: measurement engine, one reading a cycle after each start.
// fields read inverted outside the valid cycle so stale use shows up.
`timescale 1ns/1ps
module tarf_meas_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic meas_start,
  output logic rd_valid,
  output logic [63:0] rd_data,
  output logic rd_neg,
  output logic [23:0] rd_mant,
  output logic rd_exp_neg,
  output logic [9:0] rd_exp
);
  localparam logic [63:0] RD_VAL = 64'h0123456789ABCDEF;
  logic alt_r;
  // signs alternate per reading so both polarities reach the ascii encoder
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_valid <= 1'b0;
      alt_r <= 1'b0;
    end else begin
      rd_valid <= meas_start;
      if (rd_valid) alt_r <= ~alt_r;
    end
  end
  always_comb begin
    rd_data = rd_valid ? RD_VAL : ~RD_VAL;
    rd_neg = rd_valid ? ~alt_r : alt_r;
    rd_mant = rd_valid ? 24'h12D687 : 24'hED2978;
    rd_exp_neg = rd_valid ? alt_r : ~alt_r;
    rd_exp = rd_valid ? 10'h07B : 10'h384;
  end
endmodule

// >>> testbench/tarf_core_tb.sv
// tarf_core_tb: commands, triggers, byte stream and memory path of tarf_core.
// engine is tarf_meas_model; checker arrives by bind.
`timescale 1ns/1ps
module tarf_core_tb import tarf_pkg::*; ;
  localparam logic [63:0] RD_VAL = 64'h0123456789ABCDEF;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  tarf_cmd_t cmd = TARF_CMD_NONE;
  tarf_fmt_t fmt_in = TARF_FMT_ASCII;
  logic fmt_wr = 1'b0, trig_count_wr = 1'b0, trig_imm = 1'b1, trig_in = 1'b0, out_ready = 1'b1;
  logic [15:0] trig_count_in = 16'h0001;
  logic meas_start, rd_valid, rd_neg, rd_exp_neg, out_valid, out_last, mem_valid, busy;
  logic [63:0] rd_data, mem_data;
  logic [23:0] rd_mant;
  logic [9:0] rd_exp;
  logic [7:0] out_byte;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int total_checks = 0;
  int starts = 0;
  int outs = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    starts <= starts + meas_start;
    outs <= outs + out_valid;
  end
  tarf_core dut (.core_clk(core_clk), .reset(reset), .cmd(cmd), .fmt_wr(fmt_wr),
    .fmt_in(fmt_in), .trig_count_in(trig_count_in), .trig_count_wr(trig_count_wr),
    .trig_imm(trig_imm), .trig_in(trig_in), .meas_start(meas_start), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_neg(rd_neg), .rd_mant(rd_mant), .rd_exp_neg(rd_exp_neg),
    .rd_exp(rd_exp), .out_valid(out_valid), .out_byte(out_byte), .out_last(out_last),
    .out_ready(out_ready), .mem_valid(mem_valid), .mem_data(mem_data), .busy(busy));
  tarf_meas_model eng (.core_clk(core_clk), .reset(reset), .meas_start(meas_start),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_neg(rd_neg), .rd_mant(rd_mant),
    .rd_exp_neg(rd_exp_neg), .rd_exp(rd_exp));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stall(input string nm);
    chk(nm, 1, 0);
    tally_and_finish();
  endtask
  // inputs move 1 ns after the edge, outputs are read settled
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic pulse_cmd(input tarf_cmd_t c);
    cmd = c;
    tick();
    cmd = TARF_CMD_NONE;
  endtask
  task automatic setup(input tarf_fmt_t f, input logic [15:0] n);
    fmt_in = f;
    trig_count_in = n;
    fmt_wr = 1;
    trig_count_wr = 1;
    tick();
    fmt_wr = 0;
    trig_count_wr = 0;
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 60 && busy !== 1'b0; k++) tick();
    if (busy !== 1'b0) stall("busy_idle");
  endtask
  task automatic push_str(input string s);
    for (int j = 0; j < s.len(); j++) exp_q.push_back(s[j]);
  endtask
  // ready stalls one cycle in four so held bytes get exercised
  task automatic take_bytes();
    int i;
    i = 0;
    for (int k = 0; k < 500 && i < exp_q.size(); k++) begin
      tick();
      out_ready = k[0] | k[1];
      if (out_valid === 1'b1 && out_ready) begin
        chk("out_byte", exp_q[i], out_byte);
        if (i == exp_q.size() - 1) chk("out_last", 1, out_last);
        else chk("out_last", 0, out_last);
        i++;
      end
    end
    // a normal exit leaves out_ready high from the final transfer
    if (i < exp_q.size()) stall("stream_done");
  endtask
  task automatic s_ascii();
    setup(TARF_FMT_ASCII, 16'h0002);
    exp_q = {};
    push_str("-1.234567E+123,");
    push_str("+1.234567E-123\n");
    pulse_cmd(TARF_CMD_READ);
    setup(TARF_FMT_REAL64, 16'h0005);
    take_bytes();
    wait_idle();
  endtask
  task automatic s_real();
    int nb;
    for (int f = 1; f <= 2; f++) begin
      nb = 4 * f;
      setup(tarf_fmt_t'(f), 16'h0001);
      exp_q = {"#", "1", 8'h30 + 8'(nb)};
      for (int j = nb - 1; j >= 0; j--) exp_q.push_back(RD_VAL[j*8 +: 8]);
      pulse_cmd(TARF_CMD_MEAS);
      take_bytes();
      wait_idle();
    end
  endtask
  task automatic s_trig();
    int b;
    int o;
    trig_imm = 0;
    b = starts;
    o = outs;
    trig_in = 1;
    tick();
    trig_in = 0;
    pulse_cmd(TARF_CMD_INIT);
    repeat (8) tick();
    chk("meas_start", b, starts);
    trig_in = 1;
    tick();
    trig_in = 0;
    for (int k = 0; k < 40 && mem_valid !== 1'b1; k++) tick();
    if (mem_valid !== 1'b1) stall("mem_wait");
    chk("mem_valid", 1, mem_valid);
    chk("mem_data", RD_VAL, mem_data);
    wait_idle();
    chk("starts", b + 1, starts);
    chk("out_valid", o, outs);
    trig_imm = 1;
  endtask
  // reset while armed: back to idle, ascii and a single scan
  task automatic s_reset();
    setup(TARF_FMT_REAL32, 16'h0002);
    trig_imm = 0;
    pulse_cmd(TARF_CMD_INIT);
    chk("busy", 1, busy);
    reset = 1;
    tick();
    chk("busy", 0, busy);
    chk("out_valid", 0, out_valid);
    chk("mem_valid", 0, mem_valid);
    chk("mem_data", 0, mem_data);
    chk("meas_start", 0, meas_start);
    reset = 0;
    trig_imm = 1;
    exp_q = {};
    push_str("-1.234567E+123\n");
    pulse_cmd(TARF_CMD_READ);
    take_bytes();
    wait_idle();
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #1 reset = 0;
    tick();
    s_ascii();
    s_real();
    s_trig();
    s_reset();
    tally_and_finish();
  end
endmodule
